/* File: verilog/decoder_register_programming.sv */
// Configuration front end: trinary programming mode and the config_variable bank.
// Assumes frames and DCC accesses arrive decoded and synchronous to core_clk.
module decoder_register_programming
    import decoder_cfg_pkg::*;
#(
    parameter int unsigned SLOW_HALF_CYCLES = SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF_CYCLES = FAST_HALF_CYC,
    parameter logic [7:0]  VERSION_ID       = 8'h01,  // Arbitrary value.
    parameter logic [7:0]  MAKER_ID         = 8'h5a   // Arbitrary value.
)(
    input  wire logic     core_clk,
    input  wire logic     reset_n,
    input  wire logic     track_power,
    input  trinary_frame_t frame_in,
    input  dcc_access_t   dcc_in,
    output logic [7:0]    dcc_read_data,
    output logic          dcc_read_valid,
    output logic          prog_mode,
    output logic          light_flash,
    output addr_config_t  addr_cfg,
    output logic [9:0]    func_state
);

    typedef struct packed {
        logic [NUM_SLOTS-1:0][7:0] cv;
        prog_phase_t               phase;
        logic                      prog_r;
        logic                      power_q;
        logic                      armed;
        logic                      got_entry;
        logic [7:0]                entry;
        logic [9:0]                number;
        logic [7:0]                rd_data;
        logic                      rd_valid;
        addr_config_t              cfg;
        logic [9:0]                funcs;
    } prog_state_t;

    prog_state_t          st_r;
    prog_state_t          st_nxt;
    logic                 wr_en;
    logic [9:0]           wr_num;
    logic [7:0]           wr_val;
    logic                 addr_ok;
    logic                 ext_addr;
    logic [NUM_SLOTS-1:0] rd_hit;
    logic [7:0]           slot_rd;

    // Joins the preset hundreds and tens with an entered units digit.
    function automatic logic [11:0] join_digits(input logic [7:0] high, input logic [7:0] unit);
        logic [11:0] base;
        logic [3:0]  u;
        base = 12'(high) * 12'(DIGIT_WEIGHT);
        u = (unit == DIGIT_ZERO_ALT) ? 4'h0 : unit[3:0];
        join_digits = base + 12'(u);
    endfunction : join_digits

    // True when an entry is a units digit to be joined with a preset.
    function automatic logic use_digits(input logic [7:0] high, input logic [7:0] unit);
        use_digits = (high != 8'h00) && (unit <= DIGIT_ZERO_ALT);
    endfunction : use_digits

    // Read decode of the writable slots, one comparator per slot.
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++)
        begin : g_slot
            assign rd_hit[g] = (dcc_in.number == SLOT_NUM[g]);
        end
    endgenerate

    always_comb
    begin
        slot_rd = 8'h00;
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
            if (rd_hit[i])
                slot_rd = st_r.cv[i];
        end
    end

    assign ext_addr = st_r.cv[S_CONFIG][EXT_ADDR_BIT];
    assign addr_ok  = (frame_in.address == st_r.cv[S_SHORT]) || (frame_in.address == PROG_ADDR);

    // Next-state logic: programming sequence, DCC accesses, variable writes, output images.
    always_comb
    begin
        st_nxt          = st_r;
        wr_en           = 1'b0;
        wr_num          = 10'h000;
        wr_val          = 8'h00;
        st_nxt.power_q  = track_power;
        st_nxt.rd_valid = 1'b0;

        // A fresh power return arms entry; only the first frame after it may open the mode.
        if (track_power && !st_r.power_q)
            st_nxt.armed = 1'b1;

        if (!track_power)
        begin
            st_nxt.phase     = PH_IDLE;
            st_nxt.armed     = 1'b0;
            st_nxt.got_entry = 1'b0;
        end
        else if (frame_in.valid)
        begin
            st_nxt.armed = 1'b0;
            case (st_r.phase)
                PH_IDLE:
                begin
                    if (st_r.armed && frame_in.dir_change && addr_ok && (frame_in.funcs == 5'h00))
                    begin
                        st_nxt.phase     = PH_NUMBER;
                        st_nxt.got_entry = 1'b0;
                    end
                    else if (st_r.cfg.trinary_enable && (frame_in.address == st_r.cfg.trinary_address))
                    begin
                        st_nxt.funcs[4:0] = frame_in.funcs;
                    end
                    else if (st_r.cfg.trinary_enable && (frame_in.address == st_r.cfg.trinary_address2))
                    begin
                        st_nxt.funcs[8:5] = frame_in.funcs[4:1];
                        st_nxt.funcs[9]   = frame_in.funcs[0];
                    end
                end
                PH_NUMBER:
                begin
                    // The held direction key repeats; only a change after a new entry counts.
                    if (frame_in.dir_change && st_r.got_entry && addr_ok)
                    begin
                        if (use_digits(st_r.cv[S_AUX_NUM], st_r.entry))
                            st_nxt.number = 10'(join_digits(st_r.cv[S_AUX_NUM], st_r.entry));
                        else
                            st_nxt.number = 10'(st_r.entry);
                        st_nxt.phase     = PH_VALUE;
                        st_nxt.got_entry = 1'b0;
                    end
                    else if (!frame_in.dir_change)
                    begin
                        st_nxt.entry     = frame_in.address;
                        st_nxt.got_entry = 1'b1;
                    end
                end
                PH_VALUE:
                begin
                    if (frame_in.dir_change && st_r.got_entry && addr_ok)
                    begin
                        wr_en  = 1'b1;
                        wr_num = st_r.number;
                        if (use_digits(st_r.cv[S_AUX_VAL], st_r.entry))
                            wr_val = 8'(join_digits(st_r.cv[S_AUX_VAL], st_r.entry));
                        else
                            wr_val = st_r.entry;
                        st_nxt.phase     = PH_NUMBER;
                        st_nxt.got_entry = 1'b0;
                    end
                    else if (!frame_in.dir_change)
                    begin
                        st_nxt.entry     = frame_in.address;
                        st_nxt.got_entry = 1'b1;
                    end
                end
                default:
                begin
                    st_nxt.phase = PH_IDLE;
                end
            endcase
        end

        // DCC accesses are ignored, not held, while programming mode is active.
        if (st_r.phase == PH_IDLE && st_r.cfg.dcc_enable)
        begin
            if (dcc_in.wr)
            begin
                wr_en  = 1'b1;
                wr_num = dcc_in.number;
                wr_val = dcc_in.data;
            end
            else if (dcc_in.rd)
            begin
                st_nxt.rd_valid = 1'b1;
                case (dcc_in.number)
                    CV_VERSION: st_nxt.rd_data = VERSION_ID;
                    CV_MAKER:   st_nxt.rd_data = MAKER_ID;
                    CV_PAGE_HI: st_nxt.rd_data = PAGE_HI_VAL;
                    CV_PAGE_LO: st_nxt.rd_data = PAGE_LO_VAL;
                    default:    st_nxt.rd_data = slot_rd;
                endcase
            end
        end

        // Writes: the maker number restores defaults, fixed numbers keep their value.
        if (wr_en)
        begin
            if (wr_num == CV_MAKER)
            begin
                st_nxt.cv = SLOT_DEFAULT;
            end
            else
            begin
                // A number above SHORT_MAX or a value other than the last entry clears the presets, so a later plain write is not joined.
                if (wr_num > 10'(SHORT_MAX) || wr_val != st_r.entry)
                begin
                    st_nxt.cv[S_AUX_NUM] = 8'h00;
                    st_nxt.cv[S_AUX_VAL] = 8'h00;
                end
                for (int i = 0; i < NUM_SLOTS; i++)
                begin
                    if (wr_num == SLOT_NUM[i])
                        st_nxt.cv[i] = wr_val;
                end
            end
        end

        // Address images for the command decoders, refreshed every cycle.
        st_nxt.cfg.dcc_enable       = !((st_r.cv[S_SHORT] > SHORT_MAX) && !ext_addr);
        st_nxt.cfg.long_enable      = ext_addr;
        st_nxt.cfg.long_address     = {st_r.cv[S_LONG_HI][5:0], st_r.cv[S_LONG_LO]};
        st_nxt.cfg.short_address    = st_r.cv[S_SHORT][6:0];
        st_nxt.cfg.consist_address  = st_r.cv[S_CONSIST][6:0];
        st_nxt.cfg.trinary_enable   = !ext_addr;
        st_nxt.cfg.trinary_address  = st_r.cv[S_SHORT];
        st_nxt.cfg.trinary_address2 = st_r.cv[S_ADDR2];
        st_nxt.prog_r               = (st_nxt.phase != PH_IDLE);
    end

    // State register; the variable bank starts at its delivery defaults.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r       <= '0;
            st_r.cv    <= SLOT_DEFAULT;
            st_r.phase <= PH_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Lighting shows which entry the sequence waits for.
    flash_gen #(
        .SLOW_HALF (SLOW_HALF_CYCLES),
        .FAST_HALF (FAST_HALF_CYCLES)
    ) u_flash (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .enable   (st_r.prog_r),
        .fast     (st_r.phase == PH_VALUE),
        .lamp     (light_flash)
    );

    assign prog_mode      = st_r.prog_r;
    assign dcc_read_data  = st_r.rd_data;
    assign dcc_read_valid = st_r.rd_valid;
    assign addr_cfg       = st_r.cfg;
    assign func_state     = st_r.funcs;

    // Checks on the programming sequence and the variable bank.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_entry_cause: assert property ($rose(prog_mode) |-> $past(frame_in.valid && frame_in.dir_change
        && addr_ok && track_power)) else $error("programming entered without cause");
    a_flash_dark: assert property (!prog_mode [*3] |-> !light_flash)
        else $error("lamp flashing outside programming");
    a_number_step: assert property (st_r.phase == PH_NUMBER && track_power && frame_in.valid
        && frame_in.dir_change && st_r.got_entry && addr_ok |=> st_r.phase == PH_VALUE ##1 prog_mode)
        else $error("number step did not advance");
    a_value_step: assert property (st_r.phase == PH_VALUE && track_power && frame_in.valid
        && frame_in.dir_change && st_r.got_entry && addr_ok |=> st_r.phase == PH_NUMBER)
        else $error("value step did not return");
    a_stop_exits: assert property (!track_power |=> st_r.phase == PH_IDLE ##1 !prog_mode)
        else $error("stop did not end programming");
    a_factory_reset: assert property (wr_en && wr_num == CV_MAKER |=> st_r.cv == SLOT_DEFAULT)
        else $error("defaults not restored");
    a_dcc_disable: assert property (st_r.cv[S_SHORT] > SHORT_MAX && !ext_addr |=> !addr_cfg.dcc_enable)
        else $error("DCC still enabled");
    a_second_keys: assert property (st_r.phase == PH_IDLE && track_power && frame_in.valid
        && !addr_ok && st_r.cfg.trinary_enable && frame_in.address == st_r.cfg.trinary_address2
        |=> func_state[9] == $past(frame_in.funcs[0])) else $error("F0 not mapped to F9");
    a_version_ro: assert property (dcc_in.rd && !dcc_in.wr && dcc_in.number == CV_VERSION
        && st_r.phase == PH_IDLE && st_r.cfg.dcc_enable |=> dcc_read_valid && dcc_read_data == VERSION_ID)
        else $error("version readback wrong");
    a_page_fixed: assert property (dcc_in.rd && !dcc_in.wr && dcc_in.number == CV_PAGE_LO
        && st_r.phase == PH_IDLE && st_r.cfg.dcc_enable |=> dcc_read_data == PAGE_LO_VAL)
        else $error("page index not fixed");

    c_enter_prog: cover property ($rose(prog_mode));
    c_value_write: cover property (wr_en && st_r.phase == PH_VALUE);
    c_joined_number: cover property (st_r.phase == PH_VALUE && st_r.number > 10'(SHORT_MAX));
    c_factory_reset: cover property (wr_en && wr_num == CV_MAKER);

endmodule : decoder_register_programming

/* File: verilog/decoder_cfg_pkg.sv */
// Shared constants and types for the decoder programming front end.
// Assumes a single 200 MHz core clock and frames already decoded from the track signal.
package decoder_cfg_pkg;

    // Clock rate and flashing half periods.
    localparam int unsigned CLK_KHZ        = 200_000;
    localparam int unsigned SLOW_HALF_MS   = 500;
    localparam int unsigned FAST_HALF_MS   = 125;
    localparam int unsigned SLOW_HALF_CYC  = SLOW_HALF_MS * CLK_KHZ;
    localparam int unsigned FAST_HALF_CYC  = FAST_HALF_MS * CLK_KHZ;
    localparam int unsigned FLASH_CNT_W    = 27;

    // Configuration variable numbers.
    localparam logic [9:0] CV_SHORT_ADDR   = 10'h001;
    localparam logic [9:0] CV_VERSION      = 10'h007;
    localparam logic [9:0] CV_MAKER        = 10'h008;
    localparam logic [9:0] CV_LONG_HI      = 10'h011;
    localparam logic [9:0] CV_LONG_LO      = 10'h012;
    localparam logic [9:0] CV_CONSIST      = 10'h013;
    localparam logic [9:0] CV_AUX_NUM      = 10'h01a;
    localparam logic [9:0] CV_CONFIG       = 10'h01d;
    localparam logic [9:0] CV_AUX_VAL      = 10'h01e;
    localparam logic [9:0] CV_PAGE_HI      = 10'h01f;
    localparam logic [9:0] CV_PAGE_LO      = 10'h020;
    localparam logic [9:0] CV_ADDR2        = 10'h02f;

    // Fixed values and limits.
    localparam logic [7:0] PROG_ADDR       = 8'h50;
    localparam logic [7:0] DIGIT_ZERO_ALT  = 8'h0a;
    localparam logic [7:0] PAGE_HI_VAL     = 8'h00;
    localparam logic [7:0] PAGE_LO_VAL     = 8'hff;
    localparam logic [7:0] SHORT_MAX       = 8'h7f;
    localparam logic [9:0] DIGIT_WEIGHT    = 10'h00a;
    localparam int         EXT_ADDR_BIT    = 5;

    // Writable variable storage, one slot per variable.
    localparam int         NUM_SLOTS       = 8;
    localparam int         S_SHORT         = 0;
    localparam int         S_LONG_HI       = 1;
    localparam int         S_LONG_LO       = 2;
    localparam int         S_CONSIST       = 3;
    localparam int         S_AUX_NUM       = 4;
    localparam int         S_CONFIG        = 5;
    localparam int         S_AUX_VAL       = 6;
    localparam int         S_ADDR2         = 7;
    localparam logic [NUM_SLOTS-1:0][9:0] SLOT_NUM = {CV_ADDR2, CV_AUX_VAL, CV_CONFIG, CV_AUX_NUM,
                                                      CV_CONSIST, CV_LONG_LO, CV_LONG_HI, CV_SHORT_ADDR};
    localparam logic [NUM_SLOTS-1:0][7:0] SLOT_DEFAULT = {8'h04, 8'h00, 8'h0e, 8'h00,
                                                          8'h00, 8'hff, 8'hc0, 8'h03};

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b001,
        PH_NUMBER = 3'b010,
        PH_VALUE  = 3'b100
    } prog_phase_t;

    // One decoded trinary-format frame; funcs bit 0 is F0.
    typedef struct packed {
        logic       valid;
        logic       dir_change;
        logic [7:0] address;
        logic [4:0] funcs;
    } trinary_frame_t;

    // One DCC-format variable access.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [9:0] number;
        logic [7:0] data;
    } dcc_access_t;

    // Address settings handed to the command decoders.
    typedef struct packed {
        logic        dcc_enable;
        logic        long_enable;
        logic [13:0] long_address;
        logic [6:0]  short_address;
        logic [6:0]  consist_address;
        logic        trinary_enable;
        logic [7:0]  trinary_address;
        logic [7:0]  trinary_address2;
    } addr_config_t;

endpackage : decoder_cfg_pkg

/* File: verilog/flash_gen.sv */
// Lamp flasher: slow or fast square wave while enabled, dark otherwise.
// Assumes enable and fast come from flip-flops in the same clock domain.
module flash_gen
    import decoder_cfg_pkg::*;
#(
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF = FAST_HALF_CYC
)(
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic fast,
    output logic      lamp
);

    typedef struct packed {
        logic [FLASH_CNT_W-1:0] count;
        logic                   fast_r;
        logic                   lamp_r;
    } flash_state_t;

    flash_state_t st_r;
    flash_state_t st_nxt;
    logic         tick;

    // The divider restarts on a rate change so the new rate shows from its first half period.
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.fast_r = fast;
        tick          = (st_r.count == 0);
        if (!enable || (fast != st_r.fast_r))
        begin
            st_nxt.count  = FLASH_CNT_W'((fast ? FAST_HALF : SLOW_HALF) - 1);
            st_nxt.lamp_r = enable & st_r.lamp_r;
        end
        else if (tick)
        begin
            st_nxt.count  = FLASH_CNT_W'((fast ? FAST_HALF : SLOW_HALF) - 1);
            st_nxt.lamp_r = ~st_r.lamp_r;
        end
        else
        begin
            st_nxt.count = st_r.count - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign lamp = st_r.lamp_r;

endmodule : flash_gen

/* File: bench/command_station_model.sv */
// Command station model: track power and decoded trinary frames.
// Assumes frames are sampled on rising edges of core_clk.
module command_station_model
    import decoder_cfg_pkg::*;
(
    input  wire logic      core_clk,
    output trinary_frame_t frame_out,
    output logic           track_power
);
    timeunit 1ns;
    timeprecision 1ps;

    // Power starts off so that the first rise can arm programming entry.
    initial
    begin
        track_power = 1'b0;
        frame_out   = '0;
    end

    // A power rise arms entry and a power drop ends programming.
    task automatic power(input logic on);
        @(negedge core_clk);
        track_power = on;
    endtask : power

    // One frame per call; values are already weight sums chosen by the caller.
    // Fields are scrambled once valid drops so that stale data is never trusted.
    task automatic send(input logic [7:0] addr, input logic dir, input logic [4:0] funcs);
        @(negedge core_clk);
        frame_out = '{valid: 1'b1, dir_change: dir, address: addr, funcs: funcs};
        @(negedge core_clk);
        frame_out = '{valid: 1'b0, dir_change: ~dir, address: ~addr, funcs: ~funcs};
    endtask : send
endmodule : command_station_model

/* File: bench/decoder_register_programming_tb_top.sv */
// Self-checking bench for the programming front end and its variable bank.
// Assumes the command station model drives frames and the bench drives DCC accesses.
module decoder_register_programming_tb_top
    import decoder_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] VER   = 8'h3c;  // Arbitrary value.
    localparam logic [7:0] MAKER = 8'h9b;  // Arbitrary value.

    logic           core_clk = 1'b0;
    logic           reset_n  = 1'b0;
    logic           track_power;
    trinary_frame_t frame_in;
    dcc_access_t    dcc_in   = '0;
    logic [7:0]     dcc_read_data;
    logic           dcc_read_valid;
    logic           prog_mode;
    logic           light_flash;
    addr_config_t   addr_cfg;
    logic [9:0]     func_state;
    int             n_fail   = 0;
    int             compares = 0;
    logic [9:0]     rd_num [11] = '{10'h001, 10'h007, 10'h008, 10'h011, 10'h012, 10'h013,
                                    10'h01a, 10'h01e, 10'h01f, 10'h020, 10'h02f};
    logic [7:0]     rd_exp [11] = '{8'h03, VER, MAKER, 8'hc0, 8'hff, 8'h00,
                                    8'h00, 8'h00, 8'h00, 8'hff, 8'h04};

    always #2.5 core_clk = ~core_clk;

    command_station_model cs (
        .core_clk    (core_clk),
        .frame_out   (frame_in),
        .track_power (track_power)
    );

    // Short flash periods keep the run brief.
    decoder_register_programming #(
        .SLOW_HALF_CYCLES (8),
        .FAST_HALF_CYCLES (4),
        .VERSION_ID       (VER),
        .MAKER_ID         (MAKER)
    ) dut (
        .core_clk       (core_clk),
        .reset_n        (reset_n),
        .track_power    (track_power),
        .frame_in       (frame_in),
        .dcc_in         (dcc_in),
        .dcc_read_data  (dcc_read_data),
        .dcc_read_valid (dcc_read_valid),
        .prog_mode      (prog_mode),
        .light_flash    (light_flash),
        .addr_cfg       (addr_cfg),
        .func_state     (func_state)
    );

    task automatic test_done;
        $display("checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic give_up;
        n_fail++;
        $display("wrong value at %0t: wait ran out", $time);
        test_done();
    endtask : give_up

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk8

    // Write strobe lasts one cycle; the settle time covers the two-cycle image delay.
    task automatic dcc_wr(input logic [9:0] num, input logic [7:0] data);
        @(negedge core_clk);
        dcc_in = '{wr: 1'b1, rd: 1'b0, number: num, data: data};
        @(negedge core_clk);
        dcc_in = '{wr: 1'b0, rd: 1'b0, number: ~num, data: ~data};
        repeat (3) @(negedge core_clk);
    endtask : dcc_wr

    task automatic dcc_rd(input logic [9:0] num, input logic [7:0] exp);
        int i;
        @(negedge core_clk);
        dcc_in = '{wr: 1'b0, rd: 1'b1, number: num, data: 8'h00};
        @(negedge core_clk);
        dcc_in.rd = 1'b0;
        for (i = 0; i < 8 && dcc_read_valid !== 1'b1; i++)
            @(negedge core_clk);
        if (i == 8)
            give_up();
        chk8(dcc_read_data, exp, "read data");
    endtask : dcc_rd

    // Syncs to one lamp toggle first, since a phase change restarts the divider and stretches a half.
    task automatic flash_half(input logic [7:0] exp);
        int   n;
        logic last;
        for (int k = 0; k < 2; k++)
        begin
            last = light_flash;
            for (n = 0; n < 40 && light_flash === last; n++)
                @(negedge core_clk);
            if (n == 40)
                give_up();
        end
        chk8(8'(n), exp, "flash half period");
    endtask : flash_half

    task automatic prog(input logic [7:0] num, input logic [7:0] val);
        cs.send(num, 1'b0, 5'h00);
        cs.send(PROG_ADDR, 1'b1, 5'h00);
        cs.send(val, 1'b0, 5'h00);
        cs.send(PROG_ADDR, 1'b1, 5'h00);
        repeat (3) @(negedge core_clk);
    endtask : prog

    // A hang anywhere ends the run as a mismatch.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        give_up();
    end

    // Main sequence.
    initial
    begin
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        dcc_wr(10'h007, 8'h55);
        dcc_wr(10'h01f, 8'h55);
        dcc_wr(10'h020, 8'h55);
        foreach (rd_num[i]) dcc_rd(rd_num[i], rd_exp[i]);
        dcc_wr(10'h013, 8'h22);
        chk8({1'b0, addr_cfg.consist_address}, 8'h22, "consist");
        dcc_wr(10'h001, 8'h05);
        chk8({1'b0, addr_cfg.short_address}, 8'h05, "short address");
        dcc_wr(10'h001, 8'hc8);
        chk8({7'h0, addr_cfg.dcc_enable}, 8'h00, "dcc enable");
        // Entry uses the current address, which DCC can no longer reach.
        cs.power(1'b1);
        cs.send(8'hc8, 1'b1, 5'h00);
        repeat (2) @(negedge core_clk);
        chk8({7'h0, prog_mode}, 8'h01, "entry");
        flash_half(8'h08);
        cs.send(8'h08, 1'b0, 5'h00);
        cs.send(PROG_ADDR, 1'b1, 5'h00);
        flash_half(8'h04);
        cs.send(8'h21, 1'b0, 5'h00);
        cs.send(PROG_ADDR, 1'b1, 5'h00);
        repeat (3) @(negedge core_clk);
        chk8(addr_cfg.trinary_address, 8'h03, "factory reset");
        chk8({7'h0, addr_cfg.dcc_enable}, 8'h01, "dcc enable");
        flash_half(8'h08);
        dcc_wr(10'h013, 8'h07);
        // A direction change from a foreign address must not step the sequence.
        cs.send(8'h1a, 1'b0, 5'h00);
        cs.send(8'h33, 1'b1, 5'h00);
        flash_half(8'h08);
        prog(8'h1a, 8'h01);
        prog(8'h1e, 8'h14);
        prog(8'h07, 8'h0a);
        prog(8'h2f, 8'h09);
        chk8(addr_cfg.trinary_address2, 8'h09, "second address");
        cs.power(1'b0);
        repeat (3) @(negedge core_clk);
        chk8({6'h0, prog_mode, light_flash}, 8'h00, "exit");
        dcc_rd(10'h013, 8'h00);
        dcc_rd(10'h011, 8'hc8);
        chk8(addr_cfg.long_address[7:0], 8'hff, "long low");
        chk8({2'b0, addr_cfg.long_address[13:8]}, 8'h08, "long high");
        dcc_rd(10'h02f, 8'h09);
        // Keys sent to the second address land on the upper functions.
        cs.power(1'b1);
        cs.send(8'h09, 1'b0, 5'h11);
        cs.send(8'h09, 1'b0, 5'h11);
        repeat (3) @(negedge core_clk);
        chk8({3'b0, func_state[9:5]}, 8'h18, "upper keys");
        cs.power(1'b0);
        dcc_wr(10'h01d, 8'h2e);
        chk8({6'h0, addr_cfg.long_enable, addr_cfg.trinary_enable}, 8'h02, "extended mode");
        test_done();
    end
endmodule : decoder_register_programming_tb_top
